/* File: src/edc_pkg.sv */
// Purpose: shared constants and types for the emulation acknowledge control
// Assumes: one 100 MHz bus clock
// Notes: mode and state codes are one-hot
package edc_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUS_TIMEOUT_NS = 1020000; // 1.02 ms
    localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_NS / CLK_PERIOD_NS; // longest time, rounded down
    localparam int CS_CHANNELS = 4;
    localparam int WAIT_W = 4;

    // ---------------------------------------------------------------
    // vectors and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] VEC_BUS_FAULT = 8'h08;
    localparam logic [7:0] VEC_ADDR_FAULT = 8'h0C;
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [CS_CHANNELS-1:0] CS_INTERNAL_RESET = 4'h1;
    localparam logic EMU_WAIT1_RESET = 1'b0;
    localparam logic CAPTURE_RESET = 1'b0;

    // global acknowledge mode, exactly one active
    typedef enum logic [2:0] {
        MODE_MAP_INTERLOCK = 3'b001,
        MODE_TARGET_ALWAYS = 3'b010,
        MODE_EMU_ALWAYS = 3'b100
    } edc_mode_type;

    // bus cycle sequencer state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } edc_state_type;

    // configuration word
    typedef struct packed {
        logic capture;                       // trace until halt, never trigger
        logic emu_wait1;                     // emulator ack with one wait state
        edc_mode_type mode;                  // global ack mode
        logic [CS_CHANNELS-1:0] cs_internal; // per channel internal ack source
    } edc_cfg_type;

    // descriptor of one bus cycle
    typedef struct packed {
        logic cs_hit;             // a chip select covers the address
        logic [1:0] cs_sel;       // which chip select
        logic emul_mem;           // address mapped as emulation memory
        logic interlock;          // map entry asks for target ack
        logic [WAIT_W-1:0] waits; // programmed internal wait states
    } edc_cyc_type;

    localparam edc_cfg_type CFG_RESET = '{capture: CAPTURE_RESET, emu_wait1: EMU_WAIT1_RESET,
                                          mode: MODE_MAP_INTERLOCK, cs_internal: CS_INTERNAL_RESET};
endpackage

/* File: src/edc_ack_control.sv */
// Purpose: acknowledge source, wait states, bus timeout and halt control of the emulator
// Assumes: cycle and exception inputs come from logic on clock_in; target pins are asynchronous
// Notes: transfer_ack is open drain, driven low while transfer_ack_oe_out is high
//
// Contract
// - four chip selects pick internal or external ack; at reset first internal, others external
// - map interlock mode takes ack behaviour from the map entry of the access
// - interlocked emulation access waits for target ack unless internal ack exists
// - target ack always mode ends every emulation access on target ack
// - otherwise emulation accesses without internal ack end after the emulator's wait-state count
// - emulator ack always ignores map and acks everything with zero or one wait
// - emulator never drives halt; target halt sets halted status
// - fault during exception processing is a double fault; halt and stop cycles
// - bus fault vector at 08H, address fault at 0CH; odd bus vector double faults
// - halted status latches until target reset or emulator reset command
// - unacknowledged cycle ends with internal bus fault after about 1.02 ms
// - bus fault exception first writes low program counter word to stack
// - capture mode stores every cycle, never triggers, holds states before halt
`timescale 1ns/100ps
`default_nettype none
module edc_ack_control
    import edc_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
    input wire logic clock_in,              // bus clock
    input wire logic reset_n_in,            // async reset, active low
    input wire logic target_reset_n_in,     // target reset pin, active low
    input wire logic emu_reset_cmd_in,      // emulator reset command pulse
    input wire edc_cfg_type cfg_in,         // new configuration
    input wire logic cfg_load_in,           // load cfg_in pulse
    input wire logic cycle_start_in,        // bus cycle begins pulse
    input wire edc_cyc_type cycle_in,       // descriptor with cycle_start_in
    input wire logic transfer_ack_n_in,     // transfer_ack pin level, active low
    input wire logic halt_n_in,             // halt pin from target, active low
    input wire logic addr_fault_in,         // address fault pulse
    input wire logic vector_odd_in,         // fetched bus fault vector odd pulse
    input wire logic exc_done_in,           // exception processing finished pulse
    input wire logic trigger_match_in,      // analyzer trigger condition
    output logic transfer_ack_out,          // transfer_ack drive level
    output logic transfer_ack_oe_out,       // high while pulling transfer_ack low
    output logic cycle_done_out,            // cycle terminated pulse
    output logic bus_fault_signal_out,      // internal bus fault pulse
    output logic stack_write_out,           // stack write of low pc word pulse
    output logic [7:0] vector_addr_out,     // exception vector location
    output logic exc_active_out,            // exception processing in progress
    output logic bus_enable_out,            // cycles may be issued
    output logic halted_out,                // halted status
    output logic trace_store_out,           // analyzer store pulse
    output logic trace_trigger_out,         // analyzer trigger pulse
    output edc_cfg_type cfg_out             // active configuration
);
    localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // wait count reached
    function automatic logic reached(input logic [WAIT_W-1:0] cnt, input logic [WAIT_W-1:0] n);
        reached = (cnt >= n);
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d;

    // two flops per pin: ack, halt, target reset
    always_comb begin
        pin_s1_d = {target_reset_n_in, halt_n_in, transfer_ack_n_in};
        pin_s2_d = pin_s1_q;
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_s1_q <= 3'h7;
            pin_s2_q <= 3'h7;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
        end
    end

    logic ext_ack, target_halt, target_reset, clear_halt;
    assign ext_ack = !pin_s2_q[0];
    assign target_halt = !pin_s2_q[1];
    assign target_reset = !pin_s2_q[2];
    assign clear_halt = target_reset || emu_reset_cmd_in;

    // ---------------------------------------------------------------
    // main state
    // ---------------------------------------------------------------
    edc_cfg_type cfg_q, cfg_d;
    edc_state_type state_q, state_d;
    edc_cyc_type cyc_q, cyc_d;
    logic [WAIT_W-1:0] wait_q, wait_d;
    logic [TO_W-1:0] to_q, to_d;
    logic halted_q, halted_d, exc_q, exc_d, exc_bus_q, exc_bus_d;
    logic [7:0] vec_q, vec_d;
    logic done_q, done_d, fault_q, fault_d, stack_q, stack_d;
    logic drive_q, drive_d, store_q, store_d, trig_q, trig_d;
    logic internal, int_ack, emu_ack, own_ack, end_cycle, timeout, fault_now, double_fault;

    // ack source selection and sequencing
    always_comb begin
        cfg_d = cfg_q;
        state_d = state_q;
        cyc_d = cyc_q;
        wait_d = wait_q;
        to_d = to_q;
        halted_d = halted_q;
        exc_d = exc_q;
        exc_bus_d = exc_bus_q;
        vec_d = vec_q;
        done_d = 1'b0;
        fault_d = 1'b0;
        stack_d = 1'b0;
        drive_d = 1'b0;
        if (cfg_load_in) begin
            cfg_d = cfg_in;
        end
        internal = cyc_q.cs_hit && cfg_q.cs_internal[cyc_q.cs_sel];
        int_ack = internal && reached(wait_q, cyc_q.waits);
        emu_ack = reached(wait_q, {{(WAIT_W-1){1'b0}}, cfg_q.emu_wait1});
        case (cfg_q.mode)
            MODE_EMU_ALWAYS: own_ack = emu_ack;
            MODE_TARGET_ALWAYS: own_ack = int_ack && !cyc_q.emul_mem;
            default: begin
                if (!cyc_q.emul_mem) begin
                    own_ack = int_ack;
                end else if (internal) begin
                    own_ack = int_ack;
                end else begin
                    own_ack = !cyc_q.interlock && emu_ack;
                end
            end
        endcase
        if (state_q != ST_BUSY) begin
            own_ack = 1'b0;
        end
        end_cycle = (state_q == ST_BUSY) && (own_ack || ext_ack);
        timeout = (state_q == ST_BUSY) && !end_cycle && (to_q == TO_LAST);
        fault_now = timeout || addr_fault_in;
        double_fault = (fault_now && exc_q) || (vector_odd_in && exc_q && exc_bus_q);
        case (state_q)
            ST_IDLE: begin
                if (cycle_start_in && !halted_q) begin
                    state_d = ST_BUSY;
                    cyc_d = cycle_in;
                    wait_d = '0;
                    to_d = '0;
                end
            end
            ST_BUSY: begin
                wait_d = (wait_q == {WAIT_W{1'b1}}) ? wait_q : wait_q + 1'b1;
                to_d = to_q + 1'b1;
                drive_d = own_ack;
                if (end_cycle || timeout) begin
                    state_d = ST_IDLE;
                    done_d = end_cycle;
                    fault_d = timeout;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // exception entry and double fault
        if (double_fault || target_halt) begin
            halted_d = 1'b1;
        end else if (fault_now && !halted_q) begin
            exc_d = 1'b1;
            exc_bus_d = timeout;
            vec_d = timeout ? VEC_BUS_FAULT : VEC_ADDR_FAULT;
            stack_d = timeout;
        end else if (exc_done_in) begin
            exc_d = 1'b0;
        end
        if (halted_q) begin
            state_d = ST_IDLE;
        end
        if (clear_halt) begin
            halted_d = 1'b0;
            exc_d = 1'b0;
            exc_bus_d = 1'b0;
            vec_d = VEC_RESET;
            state_d = ST_IDLE;
        end
        // analyzer: store each cycle only in capture mode, trigger never in capture mode
        store_d = cfg_q.capture && (done_d || fault_d);
        trig_d = !cfg_q.capture && trigger_match_in && (done_d || fault_d);
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg_q <= CFG_RESET;
            state_q <= ST_IDLE;
            cyc_q <= '0;
            wait_q <= '0;
            to_q <= '0;
            halted_q <= 1'b0;
            exc_q <= 1'b0;
            exc_bus_q <= 1'b0;
            vec_q <= VEC_RESET;
            done_q <= 1'b0;
            fault_q <= 1'b0;
            stack_q <= 1'b0;
            drive_q <= 1'b0;
            store_q <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            state_q <= state_d;
            cyc_q <= cyc_d;
            wait_q <= wait_d;
            to_q <= to_d;
            halted_q <= halted_d;
            exc_q <= exc_d;
            exc_bus_q <= exc_bus_d;
            vec_q <= vec_d;
            done_q <= done_d;
            fault_q <= fault_d;
            stack_q <= stack_d;
            drive_q <= drive_d;
            store_q <= store_d;
            trig_q <= trig_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // halt pin is input only here
    assign transfer_ack_out = 1'b0;
    assign transfer_ack_oe_out = drive_q;
    assign cycle_done_out = done_q;
    assign bus_fault_signal_out = fault_q;
    assign stack_write_out = stack_q;
    assign vector_addr_out = vec_q;
    assign exc_active_out = exc_q;
    assign bus_enable_out = !halted_q;
    assign halted_out = halted_q;
    assign trace_store_out = store_q;
    assign trace_trigger_out = trig_q;
    assign cfg_out = cfg_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_fault_in_exc;
        exc_q && timeout && !clear_halt;
    endsequence
    sequence s_stays_halted;
        halted_q [*2];
    endsequence

    a_mode_onehot: assert property ($onehot(cfg_q.mode)) else $error("ack mode not one-hot");
    a_interlock_wait: assert property ((state_q == ST_BUSY) && (cfg_q.mode == MODE_MAP_INTERLOCK)
        && cyc_q.emul_mem && cyc_q.interlock && !internal && !ext_ack |=> !drive_q && !done_q)
        else $error("interlocked access ended without target ack");
    a_emu_zero_wait: assert property ((state_q == ST_BUSY) && (cfg_q.mode == MODE_EMU_ALWAYS)
        && !cfg_q.emu_wait1 |=> drive_q && done_q) else $error("emulator ack late");
    a_target_always: assert property ((state_q == ST_BUSY) && (cfg_q.mode == MODE_TARGET_ALWAYS)
        && cyc_q.emul_mem |=> !drive_q) else $error("emulator acked in target mode");
    a_ext_ack_ends: assert property ((state_q == ST_BUSY) && ext_ack |=> done_q)
        else $error("external ack did not end cycle");
    a_timeout_fault: assert property ((state_q == ST_BUSY) && (to_q == TO_LAST) && !end_cycle
        |=> fault_q && (state_q == ST_IDLE)) else $error("timeout fault missing");
    a_double_halts: assert property (s_fault_in_exc |=> s_stays_halted or (halted_q && clear_halt))
        else $error("double fault did not halt");
    a_halt_latched: assert property (halted_q && !clear_halt |=> halted_q)
        else $error("halt released without reset");
    a_halt_pin: assert property (target_halt && !clear_halt |=> halted_q)
        else $error("target halt ignored");
    a_no_cycles_halted: assert property (halted_q |=> state_q == ST_IDLE)
        else $error("cycle issued while halted");
    a_stack_first: assert property ($rose(exc_q) && exc_bus_q |-> stack_q && (vec_q == VEC_BUS_FAULT))
        else $error("bus fault entry wrong");
    a_capture_notrig: assert property (cfg_q.capture |=> !trig_q)
        else $error("trigger in capture mode");
endmodule
`default_nettype wire

/* File: test/edc_target_model.sv */
// Purpose: target side of the bus, drives transfer_ack and halt pins
// Assumes: pull-up on transfer_ack; emulator pulls it low through its enable
// Notes: ack delay FF means the target never acknowledges
`timescale 1ns/100ps
`default_nettype none
module edc_target_model
    import edc_pkg::*;
(
    input wire logic clock_in,           // bus clock
    input wire logic cycle_start_in,     // bus cycle begins
    input wire logic cycle_end_in,       // cycle ended by done or fault
    input wire logic emu_drive_in,       // emulator pulls transfer_ack low
    input wire logic [7:0] ack_delay_in, // cycles until ack, FF never
    input wire logic halt_req_in,        // assert the halt pin
    output logic transfer_ack_n_out,     // wired transfer_ack level
    output logic halt_n_out              // halt pin level
);
    logic [7:0] count_q = 8'h00;
    logic armed_q = 1'b0;
    logic drive_q = 1'b0;

    // ack after the delay, held until the cycle is over
    always @(posedge clock_in) begin
        if (cycle_start_in && ack_delay_in != 8'hFF) begin
            armed_q <= 1'b1;
            count_q <= ack_delay_in;
            drive_q <= (ack_delay_in == 8'h00);
        end else if (cycle_end_in) begin
            armed_q <= 1'b0;
            drive_q <= 1'b0;
        end else if (armed_q && !drive_q) begin
            count_q <= count_q - 8'h01;
            drive_q <= (count_q <= 8'h01);
        end
    end

    // pull-up: a released line reads high
    assign transfer_ack_n_out = ~(drive_q | emu_drive_in);
    assign halt_n_out = ~halt_req_in;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the acknowledge control
// Assumes: timeout shortened to TMO cycles
// Notes: driver notes expected cycle endings, a monitor compares them
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import edc_pkg::*;
    localparam int TMO = 20;
    logic clock_in, reset_n_in, target_reset_n_in, emu_reset_cmd_in, cfg_load_in, cycle_start_in;
    logic transfer_ack_n_in, halt_n_in, addr_fault_in, vector_odd_in, exc_done_in, trigger_match_in;
    logic transfer_ack_out, transfer_ack_oe_out, cycle_done_out, bus_fault_signal_out, stack_write_out;
    logic exc_active_out, bus_enable_out, halted_out, trace_store_out, trace_trigger_out, halt_req;
    logic [7:0] vector_addr_out, ack_dly, lat;
    edc_cfg_type cfg_in, cfg_out;
    edc_cyc_type cycle_in, flt;
    logic [12:0] exp_q[$];
    int miscompares, checks_done, cyc_cnt, seed;

    edc_ack_control #(.TIMEOUT_CYCLES(TMO)) u_edc_ack_control (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .target_reset_n_in(target_reset_n_in), .emu_reset_cmd_in(emu_reset_cmd_in), .cfg_in(cfg_in),
        .cfg_load_in(cfg_load_in), .cycle_start_in(cycle_start_in), .cycle_in(cycle_in),
        .transfer_ack_n_in(transfer_ack_n_in), .halt_n_in(halt_n_in), .addr_fault_in(addr_fault_in),
        .vector_odd_in(vector_odd_in), .exc_done_in(exc_done_in), .trigger_match_in(trigger_match_in),
        .transfer_ack_out(transfer_ack_out), .transfer_ack_oe_out(transfer_ack_oe_out),
        .cycle_done_out(cycle_done_out), .bus_fault_signal_out(bus_fault_signal_out),
        .stack_write_out(stack_write_out), .vector_addr_out(vector_addr_out), .exc_active_out(exc_active_out),
        .bus_enable_out(bus_enable_out), .halted_out(halted_out), .trace_store_out(trace_store_out),
        .trace_trigger_out(trace_trigger_out), .cfg_out(cfg_out));

    edc_target_model u_edc_target_model (.clock_in(clock_in), .cycle_start_in(cycle_start_in),
        .cycle_end_in(cycle_done_out | bus_fault_signal_out), .emu_drive_in(transfer_ack_oe_out),
        .ack_delay_in(ack_dly), .halt_req_in(halt_req), .transfer_ack_n_out(transfer_ack_n_in),
        .halt_n_out(halt_n_in));

    // -----------------------------------------------------------
    // clock, watchdog, tasks
    // -----------------------------------------------------------
    always #5 clock_in = ~clock_in;

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard
    always @(posedge clock_in) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock_in);
    endtask

    function automatic logic [12:0] ex(input logic [7:0] l, input logic f, input logic sk);
        return {l, f, ~f, cfg_in.capture, ~cfg_in.capture & trigger_match_in, sk};
    endfunction

    function automatic edc_cyc_type cy(input logic h, input logic [1:0] s, input logic e, input logic i,
                                       input logic [3:0] w);
        return '{cs_hit: h, cs_sel: s, emul_mem: e, interlock: i, waits: w};
    endfunction

    task automatic setcfg(input logic cap, input logic w1, input edc_mode_type m, input logic [3:0] csi);
        cfg_in = '{capture: cap, emu_wait1: w1, mode: m, cs_internal: csi};
        cfg_load_in = 1'b1;
        tick(1);
        cfg_load_in = 1'b0;
        tick(1);
        check("cfg_out", cfg_out, cfg_in);
    endtask

    // one bus cycle; the note is left for the monitor
    task automatic run_cyc(input edc_cyc_type c, input logic [7:0] d, input logic [12:0] e, input logic want);
        cycle_in = c;
        ack_dly = d;
        cycle_start_in = 1'b1;
        if (want)
            exp_q.push_back(e);
        tick(1);
        cycle_start_in = 1'b0;
        for (int i = 0; i < 40 && exp_q.size() > 0; i++)
            tick(1);
        if (exp_q.size() > 0) begin
            check("cycle_end_missing", exp_q.size(), 0);
            exp_q.delete();
        end
        tick(5);
    endtask

    // -----------------------------------------------------------
    // monitor: latency since start and the ending pulses
    // -----------------------------------------------------------
    always @(posedge clock_in)
        lat <= cycle_start_in ? 8'h01 : lat + 8'h01; // start cycle counts as one

    always @(negedge clock_in) begin
        if (reset_n_in && (cycle_done_out === 1'b1 || bus_fault_signal_out === 1'b1)) begin
            if (exp_q.size() == 0)
                check("cycle_end_unexpected", 1, 0);
            else begin
                check("cycle_end", {lat, bus_fault_signal_out, cycle_done_out, trace_store_out,
                      trace_trigger_out, stack_write_out}, exp_q.pop_front());
                check("ack_drive", transfer_ack_oe_out, cycle_done_out && ack_dly == 8'hFF);
            end
        end
    end

    initial begin
        {clock_in, reset_n_in, emu_reset_cmd_in, cfg_load_in, cycle_start_in, addr_fault_in} = '0;
        {vector_odd_in, exc_done_in, trigger_match_in, halt_req, lat, miscompares, checks_done} = '0;
        {cyc_cnt, cycle_in} = '0;
        target_reset_n_in = 1'b1;
        seed = 90;
        ack_dly = 8'hFF;
        cfg_in = CFG_RESET;
        flt = cy(1'b1, 2'h1, 1'b0, 1'b0, 4'h0);
        repeat (16) @(posedge clock_in);
        @(negedge clock_in) reset_n_in = 1'b1;
        check("cfg_reset", cfg_out, CFG_RESET);
        check("idle_reset", {halted_out, bus_enable_out, vector_addr_out, transfer_ack_out},
              {2'b01, VEC_RESET, 1'b0});
        tick(2);
        $display("test reset done");
        // map interlock, both emulator wait counts
        for (int w = 0; w < 2; w++) begin
            setcfg(1'b0, w[0], MODE_MAP_INTERLOCK, CS_INTERNAL_RESET);
            trigger_match_in = 1'b1;
            run_cyc(cy(0, 0, 1, 0, 0), 8'hFF, ex(8'(2 + w), 0, 0), 1);
            run_cyc(cy(1, 0, 0, 0, 3), 8'hFF, ex(5, 0, 0), 1);
            run_cyc(cy(1, 0, 1, 1, 3), 8'hFF, ex(5, 0, 0), 1);
            run_cyc(cy(1, 1, 1, 1, 3), 8'h04, ex(8, 0, 0), 1);
            run_cyc(cy(1, 0, 0, 0, 6), 8'h00, ex(4, 0, 0), 1);
        end
        setcfg(1'b0, 1'b0, MODE_MAP_INTERLOCK, 4'h2);
        run_cyc(cy(1, 1, 0, 0, 2), 8'hFF, ex(4, 0, 0), 1);
        $display("test map interlock done");
        setcfg(1'b0, 1'b0, MODE_TARGET_ALWAYS, CS_INTERNAL_RESET);
        run_cyc(cy(1, 0, 1, 0, 2), 8'h05, ex(9, 0, 0), 1);
        run_cyc(cy(1, 0, 0, 0, 2), 8'hFF, ex(4, 0, 0), 1);
        $display("test target ack done");
        // emulator ack always, map fields random
        for (int i = 0; i < 8; i++) begin
            setcfg(1'b1, i[0], MODE_EMU_ALWAYS, 4'h0);
            trigger_match_in = 1'($random(seed));
            run_cyc(edc_cyc_type'(9'($random(seed))), 8'hFF, ex(8'(2 + i[0]), 0, 0), 1);
        end
        $display("test emulator ack done");
        setcfg(1'b0, 1'b0, MODE_MAP_INTERLOCK, CS_INTERNAL_RESET);
        trigger_match_in = 1'b0;
        run_cyc(flt, 8'hFF, ex(8'(TMO + 1), 1, 1), 1);
        check("vector_bus", {exc_active_out, vector_addr_out}, {1'b1, VEC_BUS_FAULT});
        run_cyc(flt, 8'hFF, ex(8'(TMO + 1), 1, 0), 1);
        check("halt_double", {halted_out, bus_enable_out}, 2'b10);
        run_cyc(cy(1, 0, 0, 0, 0), 8'hFF, '0, 0);
        check("halt_kept", halted_out, 1);
        emu_reset_cmd_in = 1'b1;
        tick(1);
        emu_reset_cmd_in = 1'b0;
        tick(1);
        check("clear_cmd", {halted_out, exc_active_out, vector_addr_out}, {2'b00, VEC_RESET});
        addr_fault_in = 1'b1;
        tick(1);
        addr_fault_in = 1'b0;
        tick(1);
        check("vector_addr", {exc_active_out, vector_addr_out}, {1'b1, VEC_ADDR_FAULT});
        exc_done_in = 1'b1;
        tick(1);
        exc_done_in = 1'b0;
        tick(1);
        run_cyc(flt, 8'hFF, ex(8'(TMO + 1), 1, 1), 1);
        vector_odd_in = 1'b1;
        tick(1);
        vector_odd_in = 1'b0;
        tick(1);
        check("halt_odd", halted_out, 1);
        target_reset_n_in = 1'b0;
        tick(3);
        target_reset_n_in = 1'b1;
        tick(3);
        check("clear_target", halted_out, 0);
        halt_req = 1'b1;
        tick(4);
        halt_req = 1'b0;
        tick(6);
        check("halt_pin", halted_out, 1);
        emu_reset_cmd_in = 1'b1;
        tick(1);
        emu_reset_cmd_in = 1'b0;
        tick(1);
        check("clear_pin", halted_out, 0);
        $display("test fault and halt done");
        conclude();
    end
endmodule
`default_nettype wire
